// ===== rtl/flash_section_protection.sv
// Flash section protection for self-programming: lock gating, stall, reset vector.
// Assumes CPU, flash array and programming logic share i_clk; fuse pins are async.
`include "flash_guard_map.svh"
module flash_section_protection (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic [7:0]                i_reg_addr,
  input  wire logic [7:0]                i_reg_wdata,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  output logic      [7:0]                o_reg_rdata,
  input  wire logic                      i_store_req,
  input  wire flash_guard_pkg::prog_op_t i_store_op,
  input  wire flash_guard_pkg::waddr_t   i_store_addr,
  input  wire logic [3:0]                i_store_lock_data,
  input  wire flash_guard_pkg::waddr_t   i_exec_addr,
  input  wire logic                      i_lpm_req,
  input  wire flash_guard_pkg::waddr_t   i_lpm_addr,
  input  wire logic                      i_flash_done,
  input  wire logic                      i_chip_erase,
  input  wire logic                      i_ext_lock_wr,
  input  wire logic [3:0]                i_ext_lock_data,
  input  wire logic                      i_boot_vector_fuse,
  input  wire logic [1:0]                i_boot_size_fuses,
  output logic                           o_flash_start,
  output flash_guard_pkg::prog_op_t      o_flash_op,
  output flash_guard_pkg::waddr_t        o_flash_addr,
  output logic                           o_cpu_stall,
  output logic                           o_lpm_grant,
  output logic                           o_irq_block,
  output logic                           o_region_busy_flag,
  output flash_guard_pkg::waddr_t        o_reset_vector
);
  import flash_guard_pkg::*;

  // ****************************************************************
  // Fuse synchronisers
  // ****************************************************************
  // Fuses enter only through pins; nothing on the CPU side writes them
  logic [2:0] fuse_meta_reg;
  logic [2:0] fuse_sync_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      fuse_meta_reg <= 3'h7;
      fuse_sync_reg <= 3'h7;
    end else begin
      fuse_meta_reg <= {i_boot_vector_fuse, i_boot_size_fuses};
      fuse_sync_reg <= fuse_meta_reg;
    end
  end

  wire logic       vec_fuse  = fuse_sync_reg[2];
  wire logic [1:0] size_fuse = fuse_sync_reg[1:0];

  // ****************************************************************
  // Region classification
  // ****************************************************************
  function automatic waddr_t boot_start_of(input logic [1:0] sz);
    case (sz)
      2'h0:    boot_start_of = `BOOT_START_00;
      2'h1:    boot_start_of = `BOOT_START_01;
      2'h2:    boot_start_of = `BOOT_START_10;
      default: boot_start_of = `BOOT_START_11;
    endcase
  endfunction : boot_start_of

  wire waddr_t boot_start = boot_start_of(size_fuse);
  wire logic   exec_boot  = (i_exec_addr >= boot_start);
  wire logic   store_boot = (i_store_addr >= boot_start);
  wire logic   store_halt = (i_store_addr >= `HALT_START);
  wire logic   lpm_boot   = (i_lpm_addr >= boot_start);

  // ****************************************************************
  // Lock fields
  // ****************************************************************
  // Bit0 write lock, bit1 read lock; 1 means unprogrammed
  logic [1:0] app_lock_field_reg;
  logic [1:0] boot_lock_field_reg;
  logic [3:0] lock_and;

  wire logic app_write_lock_bit  = app_lock_field_reg[0];
  wire logic app_read_lock_bit   = app_lock_field_reg[1];
  wire logic boot_write_lock_bit = boot_lock_field_reg[0];
  wire logic boot_read_lock_bit  = boot_lock_field_reg[1];

  guard_state_t state_reg;
  guard_state_t state_next;

  wire logic idle     = (state_reg == ST_IDLE);
  // Part-wide lock bits are not inputs at all, so they cannot gate anything
  wire logic store_ok = i_store_req && idle && exec_boot;
  wire logic wr_block = store_boot ? !boot_write_lock_bit
                                   : !app_write_lock_bit;
  wire logic page_op  = store_ok && (i_store_op == OP_ERASE || i_store_op == OP_WRITE);
  wire logic fill_op  = store_ok && (i_store_op == OP_FILL);
  wire logic lock_op  = store_ok && (i_store_op == OP_LOCK);
  wire logic go       = (page_op || fill_op) && !wr_block;

  // Programming can only clear bits; a one in the data leaves the bit alone
  assign lock_and = {boot_lock_field_reg, app_lock_field_reg}
                    & (lock_op ? i_store_lock_data : 4'hF)
                    & (i_ext_lock_wr ? i_ext_lock_data : 4'hF);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      app_lock_field_reg  <= `LOCK_RESET;
      boot_lock_field_reg <= `LOCK_RESET;
    end else if (i_chip_erase) begin
      app_lock_field_reg  <= `LOCK_RESET;
      boot_lock_field_reg <= `LOCK_RESET;
    end else begin
      app_lock_field_reg  <= lock_and[1:0];
      boot_lock_field_reg <= lock_and[3:2];
    end
  end

  // ****************************************************************
  // Operation sequencer
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go && !fill_op) begin
          state_next = store_halt ? ST_HALT_PROG : ST_CONC_PROG;
        end
      end
      ST_CONC_PROG: begin
        if (i_flash_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_HALT_PROG: begin
        if (i_flash_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // Software register bus
  // ****************************************************************
  logic       vec_boot_reg;
  wire  logic ctrl_wr  = i_reg_wr && (i_reg_addr == `REG_CTRL);
  wire  logic busy_clr = ctrl_wr && i_reg_wdata[`CTRL_BUSY_CLR];
  wire  logic busy_set = (state_next == ST_CONC_PROG);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg          <= ST_IDLE;
      o_flash_start      <= 1'b0;
      o_flash_op         <= OP_ERASE;
      o_flash_addr       <= 14'h0000;
      o_cpu_stall        <= 1'b0;
      o_region_busy_flag <= 1'b0;
    end else begin
      state_reg     <= state_next;
      o_flash_start <= go;
      if (go) begin
        o_flash_op   <= i_store_op;
        o_flash_addr <= i_store_addr;
      end
      o_cpu_stall <= (state_next == ST_HALT_PROG);
      // Set wins over a clear in the same cycle
      if (busy_set) begin
        o_region_busy_flag <= 1'b1;
      end else if (busy_clr) begin
        o_region_busy_flag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Load and interrupt gating, reset vector
  // ****************************************************************
  wire logic lpm_block = lpm_boot ? (!exec_boot && !boot_read_lock_bit)
                                  : (exec_boot && !app_read_lock_bit);
  wire logic irq_block = exec_boot ? (!vec_boot_reg && !boot_read_lock_bit)
                                   : (vec_boot_reg && !app_read_lock_bit);
  wire waddr_t rst_vec = vec_fuse ? `APP_RESET_VEC : boot_start;

  wire logic [7:0] status_word = {size_fuse[0], vec_fuse, boot_lock_field_reg,
                                  app_lock_field_reg, o_cpu_stall, o_region_busy_flag};
  wire logic [7:0] rd_mux = (i_reg_addr == `REG_STATUS) ? status_word :
                            (i_reg_addr == `REG_CTRL)   ? {6'h00, vec_boot_reg, 1'b0} :
                                                          8'h00;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_lpm_grant    <= 1'b0;
      o_irq_block    <= 1'b0;
      o_reset_vector <= `APP_RESET_VEC;
      o_reg_rdata    <= 8'h00;
      vec_boot_reg   <= 1'b0;
    end else begin
      o_lpm_grant    <= i_lpm_req && !lpm_block;
      o_irq_block    <= irq_block;
      o_reset_vector <= rst_vec;
      o_reg_rdata    <= i_reg_rd ? rd_mux : 8'h00;
      if (ctrl_wr) begin
        vec_boot_reg <= i_reg_wdata[`CTRL_VEC_BOOT];
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Operation start and stall
  AST_NO_STALL_CONC: assert property (
    (state_reg == ST_CONC_PROG) |-> !o_cpu_stall)
    else $error("CPU stalled during concurrent-read operation");
  AST_NO_STALL_START: assert property (
    (idle && go && !fill_op && !store_halt) |=> !o_cpu_stall)
    else $error("CPU stalled on concurrent-read start");
  AST_STALL_HALT: assert property (
    (idle && go && !fill_op && store_halt) |=> o_cpu_stall until_with i_flash_done)
    else $error("Stall dropped before flash done");

  // Lock fields; reset stands for power-up of the store, not a clear
  AST_LOCK_PROGRAM: assert property (
    (lock_op && !i_chip_erase && !i_store_lock_data[0]) |=> !app_write_lock_bit)
    else $error("Store-program failed to program a lock bit");
  AST_CLEAR_ONLY_ERASE: assert property (
    (!$past(i_chip_erase) && !$stable(app_lock_field_reg))
      |-> ((app_lock_field_reg & ~$past(app_lock_field_reg)) == 2'h0))
    else $error("Lock bit unprogrammed without chip erase");
  AST_ERASE_RESTORES: assert property (
    i_chip_erase |=> (app_lock_field_reg == `LOCK_RESET
                      && boot_lock_field_reg == `LOCK_RESET))
    else $error("Chip erase left a lock bit programmed");

  // Write gating
  AST_APP_WRITE_LOCK: assert property (
    (page_op && !store_boot && !app_write_lock_bit) |=> !o_flash_start)
    else $error("Write to locked application region issued");
  AST_BOOT_WRITE_LOCK: assert property (
    (page_op && store_boot && !boot_write_lock_bit) |=> !o_flash_start)
    else $error("Write to locked boot region issued");
  AST_APP_FREE_WRITE: assert property (
    (page_op && !store_boot && app_lock_field_reg == 2'h3) |=> o_flash_start)
    else $error("Unlocked application write refused");
  AST_BOOT_FREE_WRITE: assert property (
    (page_op && store_boot && boot_lock_field_reg == 2'h3) |=> o_flash_start)
    else $error("Unlocked boot write refused");
  AST_APP_CODE_NO_STORE: assert property (
    (i_store_req && !exec_boot) |=> !o_flash_start)
    else $error("Store-program accepted from application code");

  // Read and interrupt gating
  AST_APP_READ_LOCK: assert property (
    (i_lpm_req && exec_boot && !lpm_boot && !app_read_lock_bit) |=> !o_lpm_grant)
    else $error("Application read from boot code granted");
  AST_BOOT_READ_LOCK: assert property (
    (i_lpm_req && !exec_boot && lpm_boot && !boot_read_lock_bit) |=> !o_lpm_grant)
    else $error("Boot read from application code granted");
  AST_FREE_READ: assert property (
    (i_lpm_req && app_lock_field_reg == 2'h3 && boot_lock_field_reg == 2'h3)
      |=> o_lpm_grant)
    else $error("Unlocked read refused");
  AST_IRQ_APP_CODE: assert property (
    (!exec_boot && vec_boot_reg && !app_read_lock_bit) |=> o_irq_block)
    else $error("Interrupt open in application code under read lock");
  AST_IRQ_BOOT_CODE: assert property (
    (exec_boot && !vec_boot_reg && !boot_read_lock_bit) |=> o_irq_block)
    else $error("Interrupt open in boot code under read lock");

  // Busy flag; software must still clear it after completion
  AST_BUSY_FLAG: assert property (
    (state_reg == ST_CONC_PROG) |-> o_region_busy_flag)
    else $error("Busy flag low while region blocked");
  AST_BUSY_SET: assert property (
    (idle && go && !fill_op && !store_halt) |=> o_region_busy_flag)
    else $error("Busy flag not raised at operation start");

  // Reset vector
  AST_RESET_VEC_APP: assert property (
    vec_fuse |=> (o_reset_vector == `APP_RESET_VEC))
    else $error("Reset vector not at application start");
  AST_RESET_VEC_BOOT: assert property (
    !vec_fuse |=> (o_reset_vector == $past(boot_start)))
    else $error("Reset vector not at boot start");

  COV_CONC_OP:  cover property (idle ##1 state_reg == ST_CONC_PROG ##[1:20] idle);
  COV_HALT_OP:  cover property (idle ##1 o_cpu_stall ##[1:20] !o_cpu_stall);
  COV_LOCK_SET: cover property (lock_op ##1 app_lock_field_reg != `LOCK_RESET);
  COV_IRQ_HELD: cover property (o_irq_block);
endmodule : flash_section_protection

// ===== shared/flash_guard_map.svh
// Offsets, field positions, reset values and region bounds of the flash guard.
// Assumes word addressing of a 16K-word program flash.
`ifndef FLASH_GUARD_MAP_SVH
`define FLASH_GUARD_MAP_SVH
`define REG_STATUS     8'h00
`define REG_CTRL       8'h04
`define CTRL_BUSY_CLR  0
`define CTRL_VEC_BOOT  1
`define ST_BUSY        0
`define ST_STALL       1
`define ST_APP_LOCK    2
`define ST_BOOT_LOCK   4
`define ST_VEC_FUSE    6
`define ST_SIZE_FUSE   7
`define LOCK_RESET     2'h3
`define APP_RESET_VEC  14'h0000
`define HALT_START     14'h3800
`define BOOT_START_00  14'h3800
`define BOOT_START_01  14'h3C00
`define BOOT_START_10  14'h3E00
`define BOOT_START_11  14'h3F00
`endif

// ===== shared/flash_guard_pkg.sv
// Types shared by the flash guard.
// Assumes flash_guard_map.svh supplies the numeric constants.
package flash_guard_pkg;
  typedef logic [13:0] waddr_t;
  typedef enum logic [1:0] {
    OP_ERASE = 2'h0,
    OP_WRITE = 2'h1,
    OP_LOCK  = 2'h2,
    OP_FILL  = 2'h3
  } prog_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CONC_PROG = 3'h2,
    ST_HALT_PROG = 3'h4
  } guard_state_t;
endpackage : flash_guard_pkg

// ===== bench/flash_array_model.sv
// Behavioural flash array answering erase and page-write commands.
// Assumes the guard's command port and one shared clock.
module flash_array_model
  import flash_guard_pkg::*;
#(
  parameter int LAT = 6
) (
  input  wire logic     i_clk,
  input  wire logic     i_rst_n,
  input  wire logic     i_start,
  input  wire prog_op_t i_op,
  output logic          o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Fills need no array time, so only erase and write answer
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (!i_rst_n) begin
      cnt <= 0;
    end else if (i_start && (i_op == OP_ERASE || i_op == OP_WRITE)) begin
      cnt <= LAT;
    end else if (cnt == 1) begin
      cnt <= 0;
      o_done <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : flash_array_model

// ===== bench/flash_section_protection_bench.sv
// Self-checking bench for the flash section protection block.
// Assumes the flash array model and the shared package and map.
`include "flash_guard_map.svh"
module flash_section_protection_bench
  import flash_guard_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, rst_n = 0, wr = 0, rd = 0, sreq = 0, lreq = 0, done;
  logic ce = 0, ewr = 0, vfuse = 1, start, stall, grant, irq, busy;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic [3:0] slock = 4'hF, edata = 4'hF;
  logic [1:0] sfuse = 2'h0;
  prog_op_t sop = OP_FILL, fop;
  waddr_t saddr = 14'h0000, eaddr = 14'h0000, laddr = 14'h0000, rvec, faddr;
  int n_mismatch = 0, checks = 0;
  always #4 i_clk = ~i_clk;
  flash_section_protection uut (.i_clk(i_clk), .i_rst_n(rst_n), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_store_req(sreq), .i_store_op(sop), .i_store_addr(saddr), .i_store_lock_data(slock),
    .i_exec_addr(eaddr), .i_lpm_req(lreq), .i_lpm_addr(laddr), .i_flash_done(done),
    .i_chip_erase(ce), .i_ext_lock_wr(ewr), .i_ext_lock_data(edata),
    .i_boot_vector_fuse(vfuse), .i_boot_size_fuses(sfuse), .o_flash_start(start),
    .o_flash_op(fop), .o_flash_addr(faddr), .o_cpu_stall(stall), .o_lpm_grant(grant),
    .o_irq_block(irq), .o_region_busy_flag(busy), .o_reset_vector(rvec));
  flash_array_model #(.LAT(6)) array (.i_clk(i_clk), .i_rst_n(rst_n), .i_start(start),
    .i_op(fop), .o_done(done));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
    @(posedge i_clk) wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a);
    @(posedge i_clk) begin addr <= a; rd <= 1'b1; end
    @(posedge i_clk) rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  // Exec address moves with the request, as the CPU would
  task automatic store(input waddr_t ex, input prog_op_t op, input waddr_t a,
                       input logic [3:0] lk);
    @(posedge i_clk) begin eaddr <= ex; sop <= op; saddr <= a; slock <= lk; sreq <= 1'b1; end
    @(posedge i_clk) sreq <= 1'b0;
    #1;
  endtask : store
  task automatic lpm(input waddr_t ex, input waddr_t a);
    @(posedge i_clk) begin eaddr <= ex; laddr <= a; lreq <= 1'b1; end
    @(posedge i_clk) lreq <= 1'b0;
    #1;
  endtask : lpm
  task automatic ext(input logic [3:0] v);
    @(posedge i_clk) begin ewr <= 1'b1; edata <= v; end
    @(posedge i_clk) ewr <= 1'b0;
  endtask : ext
  task automatic settle(input waddr_t ex);
    @(posedge i_clk) eaddr <= ex;
    repeat (3) @(posedge i_clk);
    #1;
  endtask : settle
  // Bounded wait; a lost completion ends the run
  task automatic wait_done();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge i_clk);
      #1;
      if (done) break;
    end
    if (i == 50) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wait_done
  task automatic do_reset();
    @(posedge i_clk) rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask : do_reset
  initial begin
    do_reset();
    reg_rd(`REG_STATUS); chk(d, 8'h7C);
    chk(rvec, `APP_RESET_VEC);
    reg_rd(8'h08); chk(d, 8'h00);
    $display("test reset done");
    store(14'h0100, OP_ERASE, 14'h0200, 4'hF); chk(start, 1'b0);
    store(14'h3900, OP_ERASE, 14'h0200, 4'hF); chk(start, 1'b1);
    chk(faddr, 14'h0200);
    chk(stall, 1'b0); chk(busy, 1'b1);
    wait_done(); @(posedge i_clk); #1 chk(busy, 1'b1);
    reg_wr(`REG_CTRL, 8'h01); #1 chk(busy, 1'b0);
    store(14'h3900, OP_ERASE, 14'h3A00, 4'hF); chk(stall, 1'b1);
    wait_done(); chk(stall, 1'b1);
    @(posedge i_clk); #1 chk(stall, 1'b0);
    reg_wr(`REG_CTRL, 8'h01);
    $display("test erase done");
    store(14'h3900, OP_LOCK, 14'h0000, 4'hE);
    reg_rd(`REG_STATUS); chk(d, 8'h78);
    store(14'h3900, OP_WRITE, 14'h0200, 4'hF); chk(start, 1'b0);
    chk(faddr, 14'h3A00);
    store(14'h3900, OP_FILL, 14'h3F80, 4'hF); chk(start, 1'b1);
    lpm(14'h3900, 14'h0200); chk(grant, 1'b1);
    ext(4'hD); lpm(14'h3900, 14'h0200); chk(grant, 1'b0);
    lpm(14'h0100, 14'h0200); chk(grant, 1'b1);
    reg_wr(`REG_CTRL, 8'h02); settle(14'h0100); chk(irq, 1'b1);
    settle(14'h3900); chk(irq, 1'b0);
    $display("test app lock done");
    ext(4'h3); store(14'h3900, OP_WRITE, 14'h3F80, 4'hF); chk(start, 1'b0);
    lpm(14'h0100, 14'h3F80); chk(grant, 1'b0);
    lpm(14'h3900, 14'h3F80); chk(grant, 1'b1);
    reg_wr(`REG_CTRL, 8'h00); settle(14'h3900); chk(irq, 1'b1);
    reg_rd(`REG_STATUS); chk(d, 8'h40);
    @(posedge i_clk) ce <= 1'b1;
    @(posedge i_clk) ce <= 1'b0;
    reg_rd(`REG_STATUS); chk(d, 8'h7C);
    $display("test boot lock done");
    @(posedge i_clk) begin vfuse <= 1'b0; sfuse <= 2'h1; end
    do_reset(); chk(rvec, `BOOT_START_01);
    reg_rd(`REG_STATUS); chk(d, 8'hBC);
    store(14'h3900, OP_FILL, 14'h0200, 4'hF); chk(start, 1'b0);
    store(14'h3C00, OP_FILL, 14'h0200, 4'hF); chk(start, 1'b1);
    $display("test fuses done");
    report_and_stop();
  end
endmodule : flash_section_protection_bench
